// ---- include/sbt_regs.vh ----
`ifndef SBT_REGS_VH
`define SBT_REGS_VH
// ----------------------------------------
// Scan chain geometry
// ----------------------------------------
`define SBT_IR_W        3
`define SBT_BSR_W       71
`define SBT_ID_W        32
// ----------------------------------------
// Controller states
// ----------------------------------------
`define SBT_ST_RESET    4'h0
`define SBT_ST_IDLE     4'h1
`define SBT_ST_SEL_DR   4'h2
`define SBT_ST_CAP_DR   4'h3
`define SBT_ST_SH_DR    4'h4
`define SBT_ST_EX1_DR   4'h5
`define SBT_ST_PAU_DR   4'h6
`define SBT_ST_EX2_DR   4'h7
`define SBT_ST_UPD_DR   4'h8
`define SBT_ST_SEL_IR   4'h9
`define SBT_ST_CAP_IR   4'ha
`define SBT_ST_SH_IR    4'hb
`define SBT_ST_EX1_IR   4'hc
`define SBT_ST_PAU_IR   4'hd
`define SBT_ST_EX2_IR   4'he
`define SBT_ST_UPD_IR   4'hf
// ----------------------------------------
// Instruction codes and capture pattern
// ----------------------------------------
`define SBT_OP_FLOAT    3'h0
`define SBT_OP_IDCODE   3'h1
`define SBT_OP_SAMPZ    3'h2
`define SBT_OP_SAMPLE   3'h4
`define SBT_OP_BYPASS   3'h7
`define SBT_IR_CAPTURE  3'h1
`define SBT_ID_DEFAULT  32'h00000001
`endif

// ---- rtl/sbt_sync.v ----
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser, reset value chosen by caller
module sbt_sync #(
  parameter RST_VAL = 1'b1
) (
  input  wire clk,     // Sampling clock
  input  wire rst,     // Synchronous reset
  input  wire d,       // Asynchronous input
  output reg  q_q      // Synchronised output
);
  reg meta_q;
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q_q    <= RST_VAL;
    end else begin
      meta_q <= d;
      q_q    <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/sbt_tap.v ----
// Behaviour
// - State machine steps on TMS sampled at each rising TCK edge.
// - Inputs captured on rising TCK; TDO, its enable and memory float change on falling, tap_state on rising.
// - Floating TMS and TDI read as high.
// - TDI enters the selected register MSB; TDO shows its LSB.
// - TDO driven only in shift states, otherwise high impedance.
// - Five rising TCK edges with TMS high reset the test logic.
// - Power-up reset leaves TDO high impedance.
// - Current instruction selects exactly one register between TDI and TDO.
// - Three-bit instruction shifted in Shift-IR, effective at Update-IR.
// - Instruction register holds identification instruction after reset.
// - Capture-IR loads binary 01 into the two lowest bits.
// - Bypass is one bit, cleared when bypass instruction executes.
// - Boundary register is 71 bits over the I/O ring.
// - Capture-DR snapshots ring; Shift-DR shifts it out.
// - Float, sample and sample-float instructions capture the I/O ring.
// - Identification instruction captures fixed 32-bit code into ID register.
// - All eight codes decoded; reserved codes act as bypass.
// - Never drives memory or preloads buffers; only captures the ring.
// - All-zero code acts like sample and floats memory outputs.
// - Sample-float selects boundary register and floats memory outputs.
// - Update-DR under sample has no effect beyond Pause-DR.
`timescale 1ns/1ps
`default_nettype none
`include "sbt_regs.vh"
module sbt_tap #(
  parameter [2:0]  OP_FLOAT  = `SBT_OP_FLOAT,
  parameter [2:0]  OP_IDCODE = `SBT_OP_IDCODE,
  parameter [2:0]  OP_SAMPZ  = `SBT_OP_SAMPZ,
  parameter [2:0]  OP_SAMPLE = `SBT_OP_SAMPLE,
  parameter [2:0]  OP_BYPASS = `SBT_OP_BYPASS,
  parameter [31:0] ID_CODE   = `SBT_ID_DEFAULT  // Arbitrary value
) (
  input  wire        ref_clk,    // 20 MHz system clock
  input  wire        sys_rst,    // Power-up reset, active high
  input  wire        tck,        // Test clock pin
  input  wire        tms,        // Mode select pin, pulled up
  input  wire        tdi,        // Serial data in, pulled up
  input  wire [70:0] ring_in,    // I/O ring levels to capture
  output reg         tdo_o,      // Serial data out
  output reg         tdo_oe_n,   // TDO enable, low while driven
  output reg         mem_hiz_q,  // Force memory outputs high impedance
  output wire [3:0]  tap_state   // Controller state
);
  // ----------------------------------------
  // Widths and controller states
  // ----------------------------------------
  localparam IR_W  = `SBT_IR_W;
  localparam BSR_W = `SBT_BSR_W;
  localparam ID_W  = `SBT_ID_W;

  localparam [3:0] ST_RESET  = `SBT_ST_RESET;
  localparam [3:0] ST_IDLE   = `SBT_ST_IDLE;
  localparam [3:0] ST_SEL_DR = `SBT_ST_SEL_DR;
  localparam [3:0] ST_CAP_DR = `SBT_ST_CAP_DR;
  localparam [3:0] ST_SH_DR  = `SBT_ST_SH_DR;
  localparam [3:0] ST_EX1_DR = `SBT_ST_EX1_DR;
  localparam [3:0] ST_PAU_DR = `SBT_ST_PAU_DR;
  localparam [3:0] ST_EX2_DR = `SBT_ST_EX2_DR;
  localparam [3:0] ST_UPD_DR = `SBT_ST_UPD_DR;
  localparam [3:0] ST_SEL_IR = `SBT_ST_SEL_IR;
  localparam [3:0] ST_CAP_IR = `SBT_ST_CAP_IR;
  localparam [3:0] ST_SH_IR  = `SBT_ST_SH_IR;
  localparam [3:0] ST_EX1_IR = `SBT_ST_EX1_IR;
  localparam [3:0] ST_PAU_IR = `SBT_ST_PAU_IR;
  localparam [3:0] ST_EX2_IR = `SBT_ST_EX2_IR;
  localparam [3:0] ST_UPD_IR = `SBT_ST_UPD_IR;

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  // Standard sixteen-state graph, TMS picks the successor
  function [3:0] tap_next;
    input [3:0] st;
    input       tms_lvl;
    begin
      case (st)
        ST_RESET:  tap_next = tms_lvl ? ST_RESET  : ST_IDLE;
        ST_IDLE:   tap_next = tms_lvl ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: tap_next = tms_lvl ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: tap_next = tms_lvl ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  tap_next = tms_lvl ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: tap_next = tms_lvl ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: tap_next = tms_lvl ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: tap_next = tms_lvl ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: tap_next = tms_lvl ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: tap_next = tms_lvl ? ST_RESET  : ST_CAP_IR;
        ST_CAP_IR: tap_next = tms_lvl ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  tap_next = tms_lvl ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: tap_next = tms_lvl ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: tap_next = tms_lvl ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: tap_next = tms_lvl ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: tap_next = tms_lvl ? ST_SEL_DR : ST_IDLE;
        default:   tap_next = ST_RESET;
      endcase
    end
  endfunction

  // Instructions that place the boundary register in the path
  function is_ring;
    input [2:0] op;
    begin
      is_ring = (op == OP_FLOAT) || (op == OP_SAMPLE) ||
                (op == OP_SAMPZ);
    end
  endfunction

  // Instructions that float the memory outputs
  function is_float;
    input [2:0] op;
    begin
      is_float = (op == OP_FLOAT) || (op == OP_SAMPZ);
    end
  endfunction

  // Only the two shift states drive TDO
  function is_shift;
    input [3:0] st;
    begin
      is_shift = (st == ST_SH_DR) || (st == ST_SH_IR);
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire tck_s;
  wire tms_s;
  wire tdi_s;

  // TCK idles low, so its flops reset low: no false edge after reset
  sbt_sync #(.RST_VAL(1'b0)) u_tck (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   (tck),
    .q_q (tck_s)
  );

  // Pull-ups modelled by resetting to high
  sbt_sync #(.RST_VAL(1'b1)) u_tms (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   (tms),
    .q_q (tms_s)
  );

  sbt_sync #(.RST_VAL(1'b1)) u_tdi (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   (tdi),
    .q_q (tdi_s)
  );

  // ----------------------------------------
  // TCK edge detection
  // ----------------------------------------
  // Edges are seen two to three clocks late; each TCK phase must
  // therefore last at least three clocks
  reg tck_prev_q;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_s;
    end
  end

  // Held low TCK never makes an edge, so logic sleeps
  wire rise = tck_s & ~tck_prev_q;
  wire fall = ~tck_s & tck_prev_q;

  // ----------------------------------------
  // Controller
  // ----------------------------------------
  reg [3:0] st_q;
  reg [3:0] st_d;

  assign tap_state = st_q;

  always @* begin
    st_d = tap_next(st_q, tms_s);
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= ST_RESET;
    end else if (rise) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Instruction register
  // ----------------------------------------
  reg [IR_W-1:0] ir_sh_q;   // Shift stage
  reg [IR_W-1:0] ir_q;      // Active instruction
  reg [IR_W-1:0] ir_d;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ir_sh_q <= OP_IDCODE;
    end else if (rise) begin
      if (st_q == ST_CAP_IR) begin
        ir_sh_q <= `SBT_IR_CAPTURE;
      end else if (st_q == ST_SH_IR) begin
        ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
      end
    end
  end

  // New instruction lands on the falling edge inside Update-IR, so the
  // decode never changes between a capture and its shift
  always @* begin
    case (st_q)
      ST_RESET:  ir_d = OP_IDCODE;
      ST_UPD_IR: ir_d = ir_sh_q;
      default:   ir_d = ir_q;
    endcase
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ir_q <= OP_IDCODE;
    end else if (fall) begin
      ir_q <= ir_d;
    end
  end

  // Reserved codes fall into bypass so one register is always chosen
  wire sel_bsr = is_ring(ir_q);
  wire sel_id  = (ir_q == OP_IDCODE);
  wire sel_byp = ~sel_bsr & ~sel_id;

  // ----------------------------------------
  // Boundary scan register
  // ----------------------------------------
  reg [BSR_W-1:0] bsr_q;

  // Ring is sampled as it stands; a ball in transition may capture
  // either level. Nothing is ever driven back
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      bsr_q <= {BSR_W{1'b0}};
    end else if (rise && sel_bsr) begin
      if (st_q == ST_CAP_DR) begin
        bsr_q <= ring_in;
      end else if (st_q == ST_SH_DR) begin
        bsr_q <= {tdi_s, bsr_q[BSR_W-1:1]};
      end
    end
  end
  // Update-DR loads nothing: there is no preload stage

  // ----------------------------------------
  // Identification register
  // ----------------------------------------
  reg [ID_W-1:0] id_q;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      id_q <= {ID_W{1'b0}};
    end else if (rise && sel_id) begin
      if (st_q == ST_CAP_DR) begin
        id_q <= ID_CODE;
      end else if (st_q == ST_SH_DR) begin
        id_q <= {tdi_s, id_q[ID_W-1:1]};
      end
    end
  end

  // ----------------------------------------
  // Bypass register
  // ----------------------------------------
  reg byp_q;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      byp_q <= 1'b0;
    end else if (rise && sel_byp) begin
      if (st_q == ST_CAP_DR) begin
        byp_q <= 1'b0;
      end else if (st_q == ST_SH_DR) begin
        byp_q <= tdi_s;
      end
    end
  end

  // ----------------------------------------
  // Falling edge: serial output
  // ----------------------------------------
  wire dr_bit  = sel_bsr ? bsr_q[0] : (sel_id ? id_q[0] : byp_q);
  wire out_bit = (st_q == ST_SH_IR) ? ir_sh_q[0] : dr_bit;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      tdo_o    <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (fall) begin
      tdo_oe_n <= ~is_shift(st_q);
      tdo_o    <= out_bit;
    end
  end

  // ----------------------------------------
  // Falling edge: memory output float
  // ----------------------------------------
  // Follows the instruction that takes effect on the same edge
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      mem_hiz_q <= 1'b0;
    end else if (fall) begin
      mem_hiz_q <= is_float(ir_d);
    end
  end
endmodule
`default_nettype wire

// ---- testbench/sbt_tap_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sbt_regs.vh"
module sbt_tap_monitor (
  input wire logic        ref_clk,    // System clock
  input wire logic        sys_rst,    // Sync reset
  input wire logic        tck,        // Test clock pin
  input wire logic        tms,        // Mode select pin
  input wire logic        tdi,        // Serial data in
  input wire logic [70:0] ring_in,    // I/O ring levels
  input wire logic        tdo_o,      // Serial data out
  input wire logic        tdo_oe_n,   // TDO enable, low while driven
  input wire logic        mem_hiz_q,  // Memory outputs floated
  input wire logic [3:0]  tap_state   // Controller state
);
  logic       tck_q;
  logic [2:0] ones_q;
  // Raw pin edges; valid while each TCK phase spans several clocks
  always @(posedge ref_clk) begin
    tck_q <= tck;
    if (sys_rst)
      ones_q <= 3'h0;
    else if (tck && !tck_q)
      ones_q <= !tms ? 3'h0 : (ones_q == 3'h5 ? ones_q : ones_q + 3'h1);
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_oe_off_still: assert property (tap_state inside {`SBT_ST_RESET,
    `SBT_ST_IDLE, `SBT_ST_PAU_DR, `SBT_ST_PAU_IR, `SBT_ST_UPD_DR,
    `SBT_ST_UPD_IR} |-> tdo_oe_n) else $error("tdo driven outside shift");
  a_oe_on_shift: assert property ($past(tap_state, 8) == `SBT_ST_SH_DR
    && tap_state == `SBT_ST_SH_DR |-> !tdo_oe_n)
    else $error("tdo not driven in shift");
  a_out_on_low: assert property ($changed(tdo_o) || $changed(tdo_oe_n)
    || $changed(mem_hiz_q) |-> !tck) else $error("output moved, tck high");
  a_state_on_high: assert property ($changed(tap_state) |-> tck)
    else $error("state moved while tck low");
  a_five_ones: assert property ($rose(ones_q == 3'h5)
    |-> ##[1:6] tap_state == `SBT_ST_RESET) else $error("no tms reset");
  a_reset_exit: assert property ($past(tap_state) == `SBT_ST_RESET
    && tap_state != `SBT_ST_RESET |-> tap_state == `SBT_ST_IDLE)
    else $error("bad exit from reset");
  a_hiz_at_update: assert property ($rose(mem_hiz_q)
    |-> tap_state == `SBT_ST_UPD_IR) else $error("float outside update");
  a_reset_no_hiz: assert property (tap_state == `SBT_ST_RESET
    && $past(tap_state, 8) == `SBT_ST_RESET |-> !mem_hiz_q)
    else $error("float kept in reset");
endmodule
`default_nettype wire

// ---- testbench/sbt_jtag_ctl.sv ----
`timescale 1ns/1ps
`default_nettype none
module sbt_jtag_ctl (
  output var logic tck,  // Test clock, low outside frames
  output var logic tms,  // Mode select
  output var logic tdi,  // Serial data in
  input  wire logic tdo  // Serial data out
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // TDO read just before the rise that shifts the next bit in
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #200 o = tdo;
    tck = 1'b1;
    #200 tck = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/test_sbt_tap.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sbt_regs.vh"
module test_sbt_tap;
  localparam [70:0] RING = 71'h4a_5ac3_f00f_f123_4567;
  localparam [70:0] IDX  = {{39{1'b1}}, `SBT_ID_DEFAULT};
  localparam [70:0] BYX  = {{70{1'b1}}, 1'b0};
  logic ref_clk, sys_rst, tck, tms, tdi, tdo_o, tdo_oe_n, mem_hiz_q, b;
  logic [3:0]  tap_state;
  logic [70:0] got;
  // TDO has no pull: a released pin shows the inverse to catch late reads
  wire         tdo_pin = tdo_oe_n ? ~tdo_o : tdo_o;
  int          n_errors = 0;
  int          n_tests = 0;
  // Rows: opcode, memory float, scan-out with TDI held high
  logic [74:0] rows [8] = '{{`SBT_OP_FLOAT, 1'b1, RING},
    {`SBT_OP_IDCODE, 1'b0, IDX}, {`SBT_OP_SAMPZ, 1'b1, RING},
    {3'h3, 1'b0, BYX}, {`SBT_OP_SAMPLE, 1'b0, RING}, {3'h5, 1'b0, BYX},
    {3'h6, 1'b0, BYX}, {`SBT_OP_BYPASS, 1'b0, BYX}};
  sbt_jtag_ctl ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));
  sbt_tap dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
    .tdi(tdi), .ring_in(RING), .tdo_o(tdo_o), .tdo_oe_n(tdo_oe_n),
    .mem_hiz_q(mem_hiz_q), .tap_state(tap_state));
  task automatic check(input string nm, input logic [70:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic go(input logic [7:0] s, input int n);
    for (int i = 0; i < n; i++)
      ctl.step(s[i], 1'b1, b);
  endtask
  task automatic scan(input int n, input logic [70:0] d,
                      output logic [70:0] v);
    v = '1;
    for (int i = 0; i < n; i++) begin
      ctl.step(i == n - 1, d[i], b);
      v[i] = b;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #1000000;
    n_errors++;
    stop_test();
  end
  initial begin
    sys_rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 1'b0;
    check("reset outs", 71'h2, 71'({tap_state, tdo_oe_n, mem_hiz_q}));
    go(8'h00, 1);
    foreach (rows[k]) begin
      go(8'h03, 4);
      scan(3, 71'(rows[k][74:72]), got);
      check("ir capture", 71'h1, 71'(got[2:0]));
      go(8'h05, 5);
      scan(71, '1, got);
      go(8'h01, 2);
      check("dr scan", rows[k][70:0], got);
      check("mem float", 71'(rows[k][71]), 71'(mem_hiz_q));
    end
    go(8'h03, 4);
    scan(3, 71'(`SBT_OP_FLOAT), got);
    go(8'h00, 1);
    check("hiz pause", 71'h0, 71'(mem_hiz_q));
    go(8'h03, 3);
    check("hiz update", 71'h1, 71'(mem_hiz_q));
    go(8'h01, 3);
    go(8'h0f, 4);
    check("four ones", 71'(`SBT_ST_SEL_IR), 71'(tap_state));
    go(8'h01, 1);
    check("five ones", 71'(`SBT_ST_RESET), 71'(tap_state));
    go(8'h02, 4);
    check("reset hiz", 71'h0, 71'(mem_hiz_q));
    scan(71, '1, got);
    go(8'h01, 2);
    check("id after reset", IDX, got);
    stop_test();
  end
endmodule
bind sbt_tap sbt_tap_monitor u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .tck(tck), .tms(tms), .tdi(tdi), .ring_in(ring_in), .tdo_o(tdo_o),
  .tdo_oe_n(tdo_oe_n), .mem_hiz_q(mem_hiz_q), .tap_state(tap_state));
`default_nettype wire
